// ---- rtl/sac_device.sv ----
// Successive-approximation conversion control of the 16-bit converter.
// Assumes the comparator decision arrives on the user side, same clock.
//
// Contract
// [R1] Falling start strobe begins a conversion.
// [R2] Freeze the sample before any bit trial.
// [R3] Trial bits MSB first, sixteen binary steps.
// [R4] Form code, then drop busy.
// [R5] Result belongs to the conversion just started.
// [R6] Three modes: fast, normal, low power.
// [R7] Host starts no faster than 570 kSPS fast.
// [R8] Host discards first fast result after 1 ms; here the host keeps it and marks it stale.
// [R9] Host starts at most 500 kSPS normal.
// [R10] Low-power mode powers down between conversions.
// [R11] Coding select picks binary or twos complement.
// [R12] Twos complement is binary with MSB inverted.
// [R13] Overrange input gives maximum code.
// [R14] Underrange input gives minimum code.
// [R15] Coding select high means straight binary.
// [R16] Low power when low-power high, fast low.
// [R17] Reset input aborts any conversion.
// [R18] Power-down finishes current, then blocks starts.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module sac_device
    import sac_pkg::*;
(
    // Clock, reset and enable.
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Link to the host.
    sac_link_if.device link,
    // Analog front end.
    input wire logic comparator_high_i,
    input wire logic over_range_i,
    input wire logic under_range_i,
    output logic sample_hold_o,
    output logic [15:0] dac_code_o,
    output logic analog_power_on_o,
    output logic [1:0] mode_o
);

    typedef enum logic [2:0] {ST_IDLE, ST_WAKE, ST_FREEZE, ST_TRIAL, ST_DONE} sac_state_type;

    sac_state_type state;
    logic [2:0] start_sync;
    logic [2:0] pd_sync;
    logic [2:0] rst_sync;
    logic start_level;
    logic [CNT_W-1:0] cnt;
    logic [3:0] bit_idx;
    logic [15:0] trial;
    logic [15:0] result;
    logic busy;
    logic [1:0] mode;
    logic coding_binary;
    logic powered_down;

    // Start, power-down and reset pins pass three flops; a start edge, or a power-down or reset rise, counts once the last two agree.
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            start_sync <= 3'h7;
            pd_sync <= 3'h0;
            rst_sync <= 3'h0;
        end
        else if (clk_en_i)
        begin
            start_sync <= {start_sync[1:0], link.conversion_start_n};
            pd_sync <= {pd_sync[1:0], link.power_down_request};
            rst_sync <= {rst_sync[1:0], link.reset_request};
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            start_level <= 1'b1;
        else if (clk_en_i && (start_sync[1] == start_sync[2]))
            start_level <= start_sync[2];
    end

    wire start_fall = start_level && (start_sync[2:1] == 2'h0); // [R1]
    wire pd_active = pd_sync[2] && pd_sync[1];
    wire rst_active = rst_sync[2] && rst_sync[1];
    wire is_fast = link.fast_mode && !link.low_power_mode;
    wire is_lowp = link.low_power_mode && !link.fast_mode; // [R16]
    wire [1:0] next_mode = is_fast ? 2'h1 : (is_lowp ? 2'h2 : 2'h0); // [R6]
    wire cnt_done = (cnt == '0);
    wire [15:0] bit_mask = CODE_MSB >> bit_idx; // [R3]
    wire [15:0] kept = comparator_high_i ? (trial & ~bit_mask) : trial;
    wire [15:0] next_trial = (bit_idx == 4'(MSB_POS)) ? kept : (kept | (bit_mask >> 1));
    // Clamp beats the trial result at the end codes.
    wire [15:0] bin_code = over_range_i ? CODE_FULL : (under_range_i ? CODE_ZERO : kept); // [R13] [R14]
    wire [15:0] out_code = coding_binary ? bin_code : (bin_code ^ CODE_MSB); // [R11] [R12] [R15]
    wire can_start = start_fall && !pd_active && !powered_down; // [R18]

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= ST_IDLE;
            cnt <= '0;
            bit_idx <= '0;
            trial <= CODE_ZERO;
            result <= CODE_ZERO;
            busy <= 1'b0;
            mode <= 2'h0;
            coding_binary <= 1'b1;
            powered_down <= 1'b0;
        end
        else if (clk_en_i)
        begin
            if (rst_active)
            begin
                state <= ST_IDLE; // [R17]
                busy <= 1'b0;
                trial <= CODE_ZERO;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        mode <= next_mode;
                        coding_binary <= link.output_coding_select;
                        powered_down <= pd_active;
                        if (can_start)
                        begin
                            busy <= 1'b1;
                            if (mode == 2'h2)
                            begin
                                state <= ST_WAKE;
                                cnt <= CNT_W'(WAKE_CYC - 1);
                            end
                            else
                            begin
                                state <= ST_FREEZE; // [R1] [R2]
                                cnt <= CNT_W'(FREEZE_CYC - 1);
                            end
                        end
                    end
                    ST_WAKE:
                    begin
                        cnt <= cnt - 1'b1;
                        if (cnt_done)
                        begin
                            state <= ST_FREEZE; // [R2]
                            cnt <= CNT_W'(FREEZE_CYC - 1);
                        end
                    end
                    ST_FREEZE:
                    begin
                        cnt <= cnt - 1'b1;
                        if (cnt_done)
                        begin
                            state <= ST_TRIAL;
                            bit_idx <= '0;
                            trial <= CODE_MSB; // [R3]
                            cnt <= CNT_W'(TRIAL_CYC - 1);
                        end
                    end
                    ST_TRIAL:
                    begin
                        cnt <= cnt - 1'b1;
                        if (cnt_done)
                        begin
                            trial <= next_trial; // [R3]
                            cnt <= CNT_W'(TRIAL_CYC - 1);
                            bit_idx <= bit_idx + 1'b1;
                            if (bit_idx == 4'(MSB_POS))
                            begin
                                result <= out_code; // [R4] [R5]
                                state <= ST_DONE;
                            end
                        end
                    end
                    ST_DONE:
                    begin
                        busy <= 1'b0; // [R4]
                        state <= ST_IDLE;
                    end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    // The sample is frozen from the start strobe on, through any wake-up, to the last trial.
    wire hold_state = (state == ST_WAKE) || (state == ST_FREEZE) || (state == ST_TRIAL);

    // Front-end outputs, all registered.
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            sample_hold_o <= 1'b0;
            dac_code_o <= CODE_ZERO;
            analog_power_on_o <= 1'b1;
            mode_o <= 2'h0;
            link.busy <= 1'b0;
            link.result <= CODE_ZERO;
        end
        else if (clk_en_i)
        begin
            sample_hold_o <= hold_state; // [R2]
            dac_code_o <= trial;
            // Low-power mode and power-down keep the analog core off while idle.
            analog_power_on_o <= !((state == ST_IDLE) && ((mode == 2'h2) || powered_down)); // [R10]
            mode_o <= mode;
            link.busy <= busy;
            link.result <= result;
        end
    end

endmodule : sac_device

// ---- rtl/sac_pkg.sv ----
// Shared constants and types for the converter control device and its host.
// Assumes a single 50 MHz system clock on both ends.
package sac_pkg;

    localparam int CLK_MHZ = 50;
    localparam int CODE_W = 16;
    localparam logic [15:0] CODE_ZERO = 16'h0000;
    localparam logic [15:0] CODE_FULL = 16'hffff;
    localparam logic [15:0] CODE_MSB = 16'h8000;
    localparam int MSB_POS = 15;
    // Converter timing, in nanoseconds.
    localparam int FREEZE_NS = 40;
    localparam int TRIAL_NS = 60;
    localparam int WAKE_NS = 200;
    localparam int FREEZE_CYC = (FREEZE_NS * CLK_MHZ + 999) / 1000;
    localparam int TRIAL_CYC = (TRIAL_NS * CLK_MHZ + 999) / 1000;
    localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    // Host pacing: least sample period per mode and warp idle limit.
    localparam int FAST_RATE_KSPS = 570;
    localparam int NORM_RATE_KSPS = 500;
    localparam int LOWP_RATE_KSPS = 500;
    localparam int WARP_IDLE_US = 1000;
    localparam int FAST_PER_CYC = (CLK_MHZ * 1000 + FAST_RATE_KSPS - 1) / FAST_RATE_KSPS;
    localparam int NORM_PER_CYC = (CLK_MHZ * 1000 + NORM_RATE_KSPS - 1) / NORM_RATE_KSPS;
    localparam int WARP_IDLE_CYC = WARP_IDLE_US * CLK_MHZ;
    localparam int PACE_W = 20;
    localparam int LOW_PULSE_CYC = 2;

    // APB register offsets of the host controller.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    localparam int CTRL_START = 0;
    localparam int CTRL_MODE_LO = 1;
    localparam int CTRL_CODING = 3;
    localparam int CTRL_PD = 4;
    localparam int CTRL_RESET = 5;

    typedef enum logic [1:0] {SAC_MODE_NORMAL, SAC_MODE_FAST, SAC_MODE_LOWP} sac_mode_type;

    function automatic logic [1:0] sac_mode_pins(input logic [1:0] mode);
        // Returns {fast, low_power}.
        sac_mode_pins = (mode == 2'h1) ? 2'h2 : ((mode == 2'h2) ? 2'h1 : 2'h0);
    endfunction : sac_mode_pins

endpackage : sac_pkg

// ---- rtl/sac_link_if.sv ----
// Pin-level link between the converter control device and its host.
// Assumes both ends share one clock; the device resynchronises the start, power-down and reset inputs.
`timescale 1ns/1ps
interface sac_link_if;
    logic conversion_start_n;
    logic fast_mode;
    logic low_power_mode;
    logic output_coding_select;
    logic power_down_request;
    logic reset_request;
    logic busy;
    logic [15:0] result;

    modport device (
        input conversion_start_n, fast_mode, low_power_mode, output_coding_select,
        input power_down_request, reset_request,
        output busy, result
    );
    modport host (
        output conversion_start_n, fast_mode, low_power_mode, output_coding_select,
        output power_down_request, reset_request,
        input busy, result
    );
endinterface : sac_link_if

// ---- rtl/sac_host.sv ----
// Host controller for the converter: APB registers drive the link pins.
// Assumes an APB master on the same clock as the device end.
`timescale 1ns/1ps
module sac_host
    import sac_pkg::*;
(
    // Clock, reset and enable.
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Link to the device.
    sac_link_if.host link
);

    logic [1:0] mode;
    logic coding;
    logic pd;
    logic rst;
    logic start_pend;
    logic [PACE_W-1:0] low_cnt;
    logic [PACE_W-1:0] pace_cnt;
    logic [PACE_W-1:0] idle_cnt;
    logic busy_d;
    logic discard;
    logic result_valid;
    logic result_stale;

    wire wr = psel_i && penable_i && pwrite_i && clk_en_i;
    wire rd_hit = (paddr_i == REG_CTRL) || (paddr_i == REG_STATUS) || (paddr_i == REG_RESULT);
    wire [1:0] pins = sac_mode_pins(mode);
    wire [PACE_W-1:0] period = (mode == 2'h1) ? PACE_W'(FAST_PER_CYC) : PACE_W'(NORM_PER_CYC); // [R7] [R9]
    // Pacing counts the time since the last start, so a mode change cannot shorten a gap.
    wire pace_ok = (pace_cnt >= period); // [R7] [R9]
    wire fire = start_pend && pace_ok && !link.busy && (low_cnt == '0);
    wire done = busy_d && !link.busy;
    wire [31:0] rd_data = (paddr_i == REG_CTRL) ? {26'h0, rst, pd, coding, mode, start_pend}
        : (paddr_i == REG_STATUS) ? {28'h0, result_stale, result_valid, start_pend, link.busy}
        : (paddr_i == REG_RESULT) ? {16'h0, link.result} : 32'h0;

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mode <= 2'h0;
            coding <= 1'b1;
            pd <= 1'b0;
            rst <= 1'b0;
            start_pend <= 1'b0;
            low_cnt <= '0;
            pace_cnt <= PACE_W'(NORM_PER_CYC);
            idle_cnt <= '0;
            busy_d <= 1'b0;
            discard <= 1'b1;
            result_valid <= 1'b0;
            result_stale <= 1'b0;
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            link.conversion_start_n <= 1'b1;
            link.fast_mode <= 1'b0;
            link.low_power_mode <= 1'b0;
            link.output_coding_select <= 1'b1;
            link.power_down_request <= 1'b0;
            link.reset_request <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !rd_hit;
            prdata_o <= rd_data;
            busy_d <= link.busy;
            if (wr && paddr_i == REG_CTRL)
            begin
                mode <= (pwdata_i[CTRL_MODE_LO +: 2] == 2'h3) ? 2'h0 : pwdata_i[CTRL_MODE_LO +: 2];
                coding <= pwdata_i[CTRL_CODING];
                pd <= pwdata_i[CTRL_PD];
                rst <= pwdata_i[CTRL_RESET];
            end
            // A start request arriving with the fire clears stays pending.
            if (wr && paddr_i == REG_CTRL && pwdata_i[CTRL_START])
                start_pend <= 1'b1;
            else if (fire)
                start_pend <= 1'b0;
            if (fire)
            begin
                low_cnt <= PACE_W'(LOW_PULSE_CYC);
                pace_cnt <= '0; // [R7] [R9]
                // Fast mode after a long idle: the next result is marked stale.
                discard <= (mode == 2'h1) && (idle_cnt >= PACE_W'(WARP_IDLE_CYC)); // [R8]
                idle_cnt <= '0;
            end
            else
            begin
                if (low_cnt != '0)
                    low_cnt <= low_cnt - 1'b1;
                if (pace_cnt != PACE_W'(NORM_PER_CYC))
                    pace_cnt <= pace_cnt + 1'b1;
                if (idle_cnt != PACE_W'(WARP_IDLE_CYC))
                    idle_cnt <= idle_cnt + 1'b1;
            end
            if (done)
            begin
                result_valid <= 1'b1;
                result_stale <= discard; // [R8]
            end
            else if (psel_i && penable_i && !pwrite_i && paddr_i == REG_RESULT)
                result_valid <= 1'b0;
            link.conversion_start_n <= !(fire || (low_cnt > PACE_W'(1))); // [R1]
            link.fast_mode <= pins[1]; // [R6]
            link.low_power_mode <= pins[0]; // [R16]
            link.output_coding_select <= coding; // [R15]
            link.power_down_request <= pd; // [R18]
            link.reset_request <= rst; // [R17]
        end
    end

endmodule : sac_host

// ---- verification/sac_link_checker.sv ----
// Assertions on the link between the converter host and device ends.
// Assumes the link signals, clock and reset are wired straight in.
`timescale 1ns/1ps
module sac_link_checker (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Link pins.
    input wire logic conversion_start_n,
    input wire logic fast_mode,
    input wire logic low_power_mode,
    input wire logic output_coding_select,
    input wire logic power_down_request,
    input wire logic reset_request,
    input wire logic busy,
    input wire logic [15:0] result
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////
    logic start_n_q;
    logic [11:0] since;
    logic [7:0] busy_len;
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            start_n_q <= 1'b1;
            since <= 12'hfff;
            busy_len <= 8'h00;
        end
        else
        begin
            start_n_q <= conversion_start_n;
            since <= (start_n_q && !conversion_start_n) ? 12'h000 : since + 12'(since != 12'hfff);
            busy_len <= busy ? busy_len + 8'h01 : 8'h00;
        end
    end
    ////////////////////////////////////////
    property p_start; $fell(conversion_start_n) && !busy && !power_down_request
        && !$past(power_down_request, 4) && !reset_request |-> ##[1:8] busy; endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_pulse; $fell(conversion_start_n) |=> !conversion_start_n ##1 conversion_start_n;
    endproperty
    a_pulse: assert property (p_pulse) else $error("start strobe width");
    property p_min; $fell(busy) && !reset_request |-> busy_len >= 8'h30; endproperty
    a_min: assert property (p_min) else $error("busy too short");
    property p_max; $rose(busy) |-> ##[40:75] !busy; endproperty
    a_max: assert property (p_max) else $error("busy too long");
    property p_hold; !busy && !$past(busy) && !reset_request && !$past(reset_request)
        |-> $stable(result); endproperty
    a_hold: assert property (p_hold) else $error("result moved while idle");
    property p_pace; $fell(conversion_start_n) |-> since >= (fast_mode ? 12'h056 : 12'h062);
    endproperty
    a_pace: assert property (p_pace) else $error("starts too close");
    property p_abort; $rose(reset_request) |-> ##[1:8] !busy; endproperty
    a_abort: assert property (p_abort) else $error("reset did not abort");
    property p_pd; power_down_request && $past(power_down_request, 8) && !busy |=> !busy;
    endproperty
    a_pd: assert property (p_pd) else $error("start during power down");
    c_fast: cover property ($fell(busy) && fast_mode);
    c_lowp: cover property ($fell(busy) && low_power_mode);
    c_twos: cover property ($fell(busy) && !output_coding_select);
endmodule : sac_link_checker

// ---- verification/tb.sv ----
// Bench joining the APB host end and the device end over the link.
// Assumes a comparator model that resolves each trial against a target.
`timescale 1ns/1ps
module tb
    import sac_pkg::*;
;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic over = 1'b0;
    logic under = 1'b0;
    logic [15:0] tgt = 16'h0000;
    logic [31:0] prdata, d;
    logic pready, pslverr, hold, pwr, e;
    logic [15:0] dac;
    logic [1:0] mode;
    int error_cnt = 0;
    int checks_done = 0;
    always #10 sys_clk_i = ~sys_clk_i;
    sac_link_if u_sac_link_if ();
    sac_host u_sac_host (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .link(u_sac_link_if.host));
    sac_device u_sac_device (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
        .link(u_sac_link_if.device), .comparator_high_i(dac > tgt), .over_range_i(over),
        .under_range_i(under), .sample_hold_o(hold), .dac_code_o(dac),
        .analog_power_on_o(pwr), .mode_o(mode));
    sac_link_checker u_sac_link_checker (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
        .conversion_start_n(u_sac_link_if.conversion_start_n),
        .fast_mode(u_sac_link_if.fast_mode), .low_power_mode(u_sac_link_if.low_power_mode),
        .output_coding_select(u_sac_link_if.output_coding_select),
        .power_down_request(u_sac_link_if.power_down_request),
        .reset_request(u_sac_link_if.reset_request), .busy(u_sac_link_if.busy),
        .result(u_sac_link_if.result));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic results();
        $display("Checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] w);
        @(posedge sys_clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        // Ready, read data and error are taken at the rising edge that ends the access.
        @(posedge sys_clk_i);
        while (pready !== 1'b1)
            @(posedge sys_clk_i);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wait_busy(input logic v);
        int n;
        n = 0;
        while (u_sac_link_if.busy !== v && n < 200)
        begin
            @(negedge sys_clk_i);
            n++;
        end
        check("busy", 32'(u_sac_link_if.busy), 32'(v));
    endtask : wait_busy
    task automatic wait_valid();
        int n;
        n = 0;
        d = 32'h0;
        while (d[2] !== 1'b1 && n < 100)
        begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end
        check("valid", 32'(d[2]), 32'h1);
    endtask : wait_valid
    task automatic convert(input logic [1:0] m, input logic c, input logic [15:0] t,
        input logic o, input logic u);
        logic [15:0] x;
        x = o ? CODE_FULL : (u ? CODE_ZERO : t);
        x[MSB_POS] = x[MSB_POS] ^ !c;
        @(posedge sys_clk_i);
        tgt <= t;
        over <= o;
        under <= u;
        apb(1'b1, REG_CTRL, {28'h0, c, m, 1'b0});
        apb(1'b1, REG_CTRL, {28'h0, c, m, 1'b1});
        wait_busy(1'b1);
        check("hold", 32'(hold), 32'h1);
        wait_valid();
        apb(1'b0, REG_RESULT, 32'h0);
        check("result", d, {16'h0, x});
        check("mode", 32'(mode), 32'(m));
    endtask : convert
    ////////////////////////////////////////
    task automatic t_regs();
        apb(1'b0, REG_CTRL, 32'h0);
        check("ctrl", d, 32'h8);
        apb(1'b1, 8'h0c, 32'hffffffff);
        check("bad write", 32'(e), 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        check("bad read", d, 32'h0);
        apb(1'b1, REG_CTRL, 32'he);
        apb(1'b0, REG_CTRL, 32'h0);
        check("mode code 3", d, 32'h8);
    endtask : t_regs
    task automatic t_coding();
        logic [15:0] tv [6] = '{16'h0000, 16'h8000, 16'hffff, 16'h0001, 16'h7fff, 16'ha5c3};
        for (int i = 0; i < 12; i++)
            convert(SAC_MODE_NORMAL, i[0], tv[i / 2], 1'b0, 1'b0);
    endtask : t_coding
    task automatic t_modes();
        for (int m = 0; m < 6; m++)
        begin
            convert(2'(m / 2), m[0], 16'h4321, 1'b0, 1'b0);
            repeat (20) @(negedge sys_clk_i);
            check("power", 32'(pwr), 32'(m / 2 != 2));
        end
    endtask : t_modes
    task automatic t_clamp();
        for (int i = 0; i < 4; i++)
            convert(SAC_MODE_NORMAL, i[0], 16'h5a5a, !i[1], i[1]);
    endtask : t_clamp
    task automatic t_abort();
        apb(1'b1, REG_CTRL, 32'h9);
        wait_busy(1'b1);
        apb(1'b0, REG_STATUS, 32'h0);
        check("status busy", 32'(d[0]), 32'h1);
        apb(1'b1, REG_CTRL, 32'h28);
        repeat (8) @(negedge sys_clk_i);
        check("abort", 32'(u_sac_link_if.busy), 32'h0);
        apb(1'b1, REG_CTRL, 32'h8);
        repeat (10) @(negedge sys_clk_i);
        apb(1'b0, REG_RESULT, 32'h0);
        check("abort result", d, 32'h4321);
    endtask : t_abort
    task automatic t_pd();
        logic saw;
        saw = 1'b0;
        @(posedge sys_clk_i);
        tgt <= 16'h2468;
        apb(1'b1, REG_CTRL, 32'h9);
        wait_busy(1'b1);
        apb(1'b1, REG_CTRL, 32'h18);
        wait_valid();
        apb(1'b0, REG_RESULT, 32'h0);
        check("pd result", d, 32'h2468);
        apb(1'b1, REG_CTRL, 32'h19);
        repeat (300)
        begin
            @(negedge sys_clk_i);
            saw = saw | u_sac_link_if.busy;
        end
        check("pd start", 32'(saw), 32'h0);
        apb(1'b1, REG_CTRL, 32'h8);
        repeat (300) @(negedge sys_clk_i);
        apb(1'b0, REG_RESULT, 32'h0);
        check("pd after", d, 32'h2468);
    endtask : t_pd
    task automatic t_stale();
        repeat (WARP_IDLE_CYC) @(negedge sys_clk_i);
        convert(SAC_MODE_FAST, 1'b1, 16'h1357, 1'b0, 1'b0);
        apb(1'b0, REG_STATUS, 32'h0);
        check("stale", 32'(d[3]), 32'h1);
        convert(SAC_MODE_FAST, 1'b1, 16'h1357, 1'b0, 1'b0);
        apb(1'b0, REG_STATUS, 32'h0);
        check("fresh", 32'(d[3]), 32'h0);
    endtask : t_stale
    ////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_coding();
        t_modes();
        t_abort();
        t_pd();
        t_clamp();
        t_stale();
        results();
    end
    initial
    begin
        repeat (90000) @(posedge sys_clk_i);
        error_cnt++;
        results();
    end
endmodule : tb
